// [event_branch_unit.sv]
// event branch decode and execute unit with avalon register slave
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps

module event_branch_unit
    import event_branch_pkg::*;
#(
    parameter int BLK_W = 16
)
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // instruction fetch side
    input wire logic instr_valid,
    input wire instr_req_t instr_req,
    input wire logic hub_refill_ready,
    output logic instr_busy_q,
    output branch_rsp_t rsp_q,
    // event flag sources
    input wire event_flags_t event_flags,
    input wire logic fifo_start,
    input wire logic fifo_advance,
    output logic fifo_wrap_q,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // picks the tested flag for a destination code; bit 0 says the code is ours
    function automatic logic [1:0] flag_select(input logic [8:0] code, input event_flags_t ev, input logic wrap);
        logic [1:0] r;
        r = 2'h0;
        case (code)
            D_JUMP_ON_IRQ_FLAG: r = {ev.irq, 1'b1};
            D_JUMP_NO_IRQ_FLAG: r = {~ev.irq, 1'b1};
            D_JUMP_ON_SEL_EVENT_1: r = {ev.sel_event[0], 1'b1};
            D_JUMP_ON_SEL_EVENT_2: r = {ev.sel_event[1], 1'b1};
            D_JUMP_ON_SEL_EVENT_3: r = {ev.sel_event[2], 1'b1};
            D_JUMP_ON_SEL_EVENT_4: r = {ev.sel_event[3], 1'b1};
            D_JUMP_NO_SEL_EVENT_1: r = {~ev.sel_event[0], 1'b1};
            D_JUMP_NO_SEL_EVENT_2: r = {~ev.sel_event[1], 1'b1};
            D_JUMP_NO_SEL_EVENT_3: r = {~ev.sel_event[2], 1'b1};
            D_JUMP_NO_SEL_EVENT_4: r = {~ev.sel_event[3], 1'b1};
            D_JUMP_ON_PIN_MATCH: r = {ev.pin_match, 1'b1};
            D_JUMP_NO_PIN_MATCH: r = {~ev.pin_match, 1'b1};
            D_JUMP_ON_FIFO_WRAP: r = {wrap, 1'b1};
            D_JUMP_NO_FIFO_WRAP: r = {~wrap, 1'b1};
            D_JUMP_ON_STREAM_DONE: r = {ev.stream_done, 1'b1};
            D_JUMP_NO_STREAM_DONE: r = {~ev.stream_done, 1'b1};
            D_JUMP_ON_ROTATOR_EMPTY: r = {ev.rotator_empty, 1'b1};
            D_JUMP_NO_ROTATOR_EMPTY: r = {~ev.rotator_empty, 1'b1};
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [19:0] last_target_q;
    logic [31:0] taken_count_q;
    logic last_taken_q;
    logic last_hub_q;
    logic [BLK_W-1:0] blk_left_q;
    logic [BLK_W-1:0] blk_left_d;
    logic fifo_wrap_d;
    exec_state_t state_q;
    logic [4:0] cnt_q;
    logic [4:0] lat_q;
    logic taken_q;
    logic [19:0] target_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode and target arithmetic

    // field slices of the presented word
    wire logic [3:0] f_cond = instr_req.word[COND_HI:COND_LO];
    wire logic [6:0] f_opc = instr_req.word[OPC_HI:OPC_LO];
    wire logic [1:0] f_ext = instr_req.word[EXT_HI:EXT_LO];
    wire logic f_imm = instr_req.word[IMM_BIT];
    wire logic [8:0] f_dst = instr_req.word[DST_HI:DST_LO];
    wire logic [8:0] f_src = instr_req.word[SRC_HI:SRC_LO];

    // opcode match and flag selection
    wire logic is_group = (f_opc == OPC_EVENT_BRANCH) && (f_ext == EXT_EVENT_BRANCH);
    wire logic [1:0] sel = flag_select(f_dst, event_flags, fifo_wrap_q);
    wire logic is_event_branch = is_group && sel[0];
    wire logic flag_ok = sel[1];

    // condition field indexed by {c, z}; a failed condition is a plain no-op
    wire logic cond_ok = f_cond[{instr_req.flag_c, instr_req.flag_z}];
    wire logic will_take = is_event_branch && cond_ok && flag_ok;

    // 9-bit offset sign-extended, or 20 bits when the augment prefix is present
    wire logic [19:0] off_short = {{11{f_src[SRC_SIGN]}}, f_src};
    wire logic [19:0] off_long = {instr_req.aug_bits[AUG_LOW_HI:0], f_src};
    wire logic [19:0] off_sel = instr_req.aug_valid ? off_long : off_short;

    // shared-memory code scales by four; no alignment check because byte pcs are legal there
    wire logic [19:0] off_scaled = instr_req.hub_exec ? {off_sel[17:0], 2'b00} : off_sel;
    wire logic [19:0] pc_next = instr_req.pc + (instr_req.hub_exec ? PC_STEP_SHARED : PC_STEP_LOCAL);
    wire logic [19:0] rel_target = pc_next + off_scaled;
    wire logic [19:0] new_target = f_imm ? rel_target : instr_req.src_value;

    // latency picked at acceptance; shared taken is bounded by the hub wait state
    wire logic [4:0] new_lat = will_take ? LAT_TAKEN_LOCAL : LAT_NOT_TAKEN;

    wire logic unit_en = ctrl_q[CTRL_ENABLE_BIT];
    wire logic accept = instr_valid && (state_q == ST_IDLE) && unit_en;

    ////////////////////////////////////////////////////////////////////////////
    // execution sequencer

    // end of run: count since the accepting edge reaches the chosen latency
    wire logic run_end = (state_q == ST_RUN) && (cnt_q == (lat_q - CNT_ONE));
    wire logic hub_end = (state_q == ST_HUB_WAIT)
        && (((cnt_q >= (LAT_SHARED_MIN - CNT_ONE)) && hub_refill_ready)
        || (cnt_q == (LAT_SHARED_MAX - CNT_ONE)));
    wire logic finish = run_end || hub_end;

    // sequencer state and counters
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            lat_q <= LAT_NOT_TAKEN;
            taken_q <= 1'b0;
            target_q <= 20'h00000;
            last_hub_q <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        cnt_q <= 5'h00;
                        lat_q <= new_lat;
                        taken_q <= will_take;
                        target_q <= new_target;
                        last_hub_q <= instr_req.hub_exec;
                        state_q <= (will_take && instr_req.hub_exec) ? ST_HUB_WAIT : ST_RUN;
                    end
                end
                ST_RUN, ST_HUB_WAIT:
                begin
                    cnt_q <= cnt_q + CNT_ONE;
                    if (finish)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // answer to fetch; the pc is never loaded unless the flag test passed
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_q <= '0;
        end
        else if (clk_en)
        begin
            rsp_q.done <= finish;
            rsp_q.pc_load <= finish && taken_q;
            rsp_q.pc_target <= finish ? target_q : rsp_q.pc_target;
        end
    end

    // busy from the accepting edge to the done edge; fetch must hold its next word meanwhile
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_busy_q <= 1'b0;
        end
        else if (clk_en)
        begin
            instr_busy_q <= accept || ((state_q != ST_IDLE) && !finish);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fifo block wrap flag

    // polling the wrap flag with either form consumes it
    wire logic wrap_polled = accept && is_group && cond_ok
        && ((f_dst == D_JUMP_ON_FIFO_WRAP) || (f_dst == D_JUMP_NO_FIFO_WRAP));
    wire logic [BLK_W-1:0] blk_len = ctrl_q[CTRL_BLK_LO +: BLK_W];
    wire logic blk_last = fifo_advance && (blk_left_q == {{(BLK_W-1){1'b0}}, 1'b1});

    // count down, raise the flag on the last word, then reload the block start
    assign blk_left_d = fifo_start ? blk_len
        : (blk_last ? blk_len
        : ((fifo_advance && (blk_left_q != '0)) ? (blk_left_q - {{(BLK_W-1){1'b0}}, 1'b1}) : blk_left_q));
    // a wrap arriving with the poll wins over the clear
    assign fifo_wrap_d = blk_last ? 1'b1 : (wrap_polled ? 1'b0 : fifo_wrap_q);

    // block counter only
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blk_left_q <= '0;
        end
        else if (clk_en)
        begin
            blk_left_q <= blk_left_d;
        end
    end

    // wrap flag on its own; the set-wins merge lives in fifo_wrap_d
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_wrap_q <= 1'b0;
        end
        else if (clk_en)
        begin
            fifo_wrap_q <= fifo_wrap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file and avalon slave

    // one-cycle answer: waitrequest idles high and drops for the answering cycle
    wire logic bus_req = avs_read || avs_write;
    wire logic bus_done = bus_req && !avs_waitrequest;
    wire logic ctrl_hit = avs_address == REG_CTRL;
    wire logic [31:0] status_word = {28'h0000000, last_hub_q, last_taken_q, fifo_wrap_q, instr_busy_q};

    // read selection; unmapped addresses read zero
    wire logic [31:0] rd_mux = ctrl_hit ? ctrl_q
        : (avs_address == REG_STATUS) ? status_word
        : (avs_address == REG_LAST_TARGET) ? {12'h000, last_target_q}
        : (avs_address == REG_TAKEN_COUNT) ? taken_count_q
        : 32'h0000_0000;

    assign ctrl_d = (bus_done && avs_write && ctrl_hit) ? lane_merge(ctrl_q, avs_writedata, avs_byteenable) : ctrl_q;

    // bus handshake and read data
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            avs_readdata <= (avs_read && avs_waitrequest) ? rd_mux : avs_readdata;
        end
    end

    // control word; a write lands only at the edge that completes the access
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else if (clk_en)
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // branch history shown to software
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_target_q <= 20'h00000;
            taken_count_q <= 32'h0000_0000;
            last_taken_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (finish)
            begin
                last_taken_q <= taken_q;
            end
            if (finish && taken_q)
            begin
                last_target_q <= target_q;
                taken_count_q <= taken_count_q + 32'h0000_0001; // wraps silently
            end
        end
    end

endmodule

// [event_branch_pkg.sv]
// constants, field layouts and carriers for the event branch unit
package event_branch_pkg;

    // instruction word layout
    localparam int COND_HI = 31;
    localparam int COND_LO = 28;
    localparam int OPC_HI = 27;
    localparam int OPC_LO = 21;
    localparam int EXT_HI = 20;
    localparam int EXT_LO = 19;
    localparam int IMM_BIT = 18;
    localparam int DST_HI = 17;
    localparam int DST_LO = 9;
    localparam int SRC_HI = 8;
    localparam int SRC_LO = 0;
    localparam int SRC_SIGN = 8;
    localparam int AUG_LOW_HI = 10;

    localparam logic [6:0] OPC_EVENT_BRANCH = 7'h5E;
    localparam logic [1:0] EXT_EVENT_BRANCH = 2'h1;

    // destination codes of the event branch group
    localparam logic [8:0] D_JUMP_ON_IRQ_FLAG = 9'h000;
    localparam logic [8:0] D_JUMP_NO_IRQ_FLAG = 9'h010;
    localparam logic [8:0] D_JUMP_ON_SEL_EVENT_1 = 9'h004;
    localparam logic [8:0] D_JUMP_ON_SEL_EVENT_2 = 9'h005;
    localparam logic [8:0] D_JUMP_ON_SEL_EVENT_3 = 9'h006;
    localparam logic [8:0] D_JUMP_ON_SEL_EVENT_4 = 9'h007;
    localparam logic [8:0] D_JUMP_NO_SEL_EVENT_1 = 9'h014;
    localparam logic [8:0] D_JUMP_NO_SEL_EVENT_2 = 9'h015;
    localparam logic [8:0] D_JUMP_NO_SEL_EVENT_3 = 9'h016;
    localparam logic [8:0] D_JUMP_NO_SEL_EVENT_4 = 9'h017;
    localparam logic [8:0] D_JUMP_ON_PIN_MATCH = 9'h008;
    localparam logic [8:0] D_JUMP_NO_PIN_MATCH = 9'h018;
    localparam logic [8:0] D_JUMP_ON_FIFO_WRAP = 9'h009;
    localparam logic [8:0] D_JUMP_NO_FIFO_WRAP = 9'h019;
    localparam logic [8:0] D_JUMP_ON_STREAM_DONE = 9'h00B;
    localparam logic [8:0] D_JUMP_NO_STREAM_DONE = 9'h01B;
    localparam logic [8:0] D_JUMP_ON_ROTATOR_EMPTY = 9'h00F;
    localparam logic [8:0] D_JUMP_NO_ROTATOR_EMPTY = 9'h01F;

    // execution cycle counts, measured from the accepting edge
    localparam logic [4:0] LAT_NOT_TAKEN = 5'h02;
    localparam logic [4:0] LAT_TAKEN_LOCAL = 5'h04;
    localparam logic [4:0] LAT_SHARED_MIN = 5'h0D;
    localparam logic [4:0] LAT_SHARED_MAX = 5'h14;
    localparam logic [4:0] CNT_ONE = 5'h01;

    // program counter
    localparam int PC_W = 20;
    localparam logic [19:0] PC_STEP_LOCAL = 20'h00001;
    localparam logic [19:0] PC_STEP_SHARED = 20'h00004;

    // register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LAST_TARGET = 4'h8;
    localparam logic [3:0] REG_TAKEN_COUNT = 4'hC;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_BLK_LO = 16;
    localparam int CTRL_BLK_HI = 31;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WRAP_BIT = 1;
    localparam int STAT_TAKEN_BIT = 2;
    localparam int STAT_HUB_BIT = 3;

    // one instruction presented by fetch
    typedef struct packed {
        logic [31:0] word;
        logic [19:0] pc;
        logic [19:0] src_value;
        logic aug_valid;
        logic [22:0] aug_bits;
        logic flag_c;
        logic flag_z;
        logic hub_exec;
    } instr_req_t;

    // event flag levels from the sources outside
    typedef struct packed {
        logic irq;
        logic [3:0] sel_event;
        logic pin_match;
        logic stream_done;
        logic rotator_empty;
    } event_flags_t;

    // answer to fetch
    typedef struct packed {
        logic done;
        logic pc_load;
        logic [19:0] pc_target;
    } branch_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HUB_WAIT
    } exec_state_t;

endpackage

// [event_branch_unit_monitor.sv]
// assertion checker bound to the event branch unit ports
`timescale 1ns/10ps
module event_branch_unit_monitor
    import event_branch_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // fetch side
    input wire instr_req_t instr_req,
    input wire logic instr_busy_q,
    input wire branch_rsp_t rsp_q,
    // fifo and bus
    input wire logic fifo_advance,
    input wire logic fifo_wrap_q,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // timing after accept; busy rises at the accepting edge and is sampled high one edge later
    a_local_time: assert property (
        $rose(instr_busy_q) && !$past(instr_req.hub_exec) |-> ##2
        ((rsp_q.done && !rsp_q.pc_load) or (!rsp_q.done ##2 (rsp_q.done && rsp_q.pc_load))))
        else $error("local branch answered at wrong cycle");
    a_shared_time: assert property (
        $rose(instr_busy_q) && $past(instr_req.hub_exec) |-> ##2
        ((rsp_q.done && !rsp_q.pc_load) or (!rsp_q.done [*8] ##[4:11] (rsp_q.done && rsp_q.pc_load))))
        else $error("shared branch answered outside 13 to 20 cycles");
    a_done_pulse: assert property (rsp_q.done |=> !rsp_q.done)
        else $error("done longer than one cycle");
    a_load_done: assert property (rsp_q.pc_load |-> rsp_q.done && !instr_busy_q)
        else $error("pc load outside the done cycle");
    a_target_hold: assert property (!rsp_q.done |-> $stable(rsp_q.pc_target))
        else $error("target moved between answers");
    // gated or foreign words must answer as a plain no-op
    a_never_cond: assert property (
        $rose(instr_busy_q) && $past(instr_req.word[31:28]) == 4'h0 |-> ##2 (rsp_q.done && !rsp_q.pc_load))
        else $error("never-condition branch was taken");
    a_foreign_word: assert property (
        $rose(instr_busy_q) && $past(instr_req.word[27:19]) != {OPC_EVENT_BRANCH, EXT_EVENT_BRANCH}
        |-> ##2 (rsp_q.done && !rsp_q.pc_load))
        else $error("non-group word loaded the pc");
    a_wrap_cause: assert property ($rose(fifo_wrap_q) |-> $past(fifo_advance))
        else $error("wrap flag set without a consumed word");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus access not answered in one cycle");
    // main scenarios reached
    c_taken: cover property ($rose(instr_busy_q) ##[1:19] rsp_q.pc_load);
    c_wrap: cover property ($rose(fifo_wrap_q));
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind event_branch_unit event_branch_unit_monitor mon_u (.core_clk, .rst_n, .instr_req, .instr_busy_q, .rsp_q,
    .fifo_advance, .fifo_wrap_q, .avs_read, .avs_write, .avs_waitrequest);

// [hub_refill_model.sv]
// shared-memory refill model answering taken hub branches
`timescale 1ns/10ps
module hub_refill_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // refill handshake
    input wire logic instr_busy_q,
    input wire logic [4:0] delay,
    output logic hub_refill_ready
);
    logic [4:0] cnt_q;
    // counts busy cycles; saturates at 31 so ready stays high once reached
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 5'h00;
        else if (!instr_busy_q)
            cnt_q <= 5'h00;
        else if (cnt_q != 5'h1F)
            cnt_q <= cnt_q + 5'h01;
    end
    // ready drops when no branch is pending, never left standing high
    assign hub_refill_ready = instr_busy_q && (cnt_q >= delay);
endmodule

// [event_branch_unit_bench.sv]
// self-checking bench for the event branch unit
`timescale 1ns/10ps
module event_branch_unit_bench
    import event_branch_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic instr_valid = 1'b0;
    instr_req_t req = '0;
    event_flags_t flags = '0;
    logic fifo_start = 1'b0;
    logic fifo_advance = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [4:0] delay = 5'h00;
    logic hub_refill_ready, instr_busy_q, fifo_wrap_q, avs_waitrequest;
    branch_rsp_t rsp_q;
    logic [31:0] avs_readdata, rd;
    logic [19:0] last_tgt = 20'h0;
    int mismatches = 0;
    int checks_done = 0;
    int taken_n = 0;
    logic [8:0] codes [8] = '{9'h000, 9'h004, 9'h005, 9'h006, 9'h007, 9'h008, 9'h00B, 9'h00F};
    int bits [8] = '{7, 3, 4, 5, 6, 2, 1, 0};
    // free-running core clock
    always #5 core_clk = ~core_clk;
    event_branch_unit dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .instr_valid(instr_valid),
        .instr_req(req), .hub_refill_ready(hub_refill_ready), .instr_busy_q(instr_busy_q), .rsp_q(rsp_q),
        .event_flags(flags), .fifo_start(fifo_start), .fifo_advance(fifo_advance), .fifo_wrap_q(fifo_wrap_q),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    hub_refill_model hub_u (.core_clk(core_clk), .rst_n(rst_n), .instr_busy_q(instr_busy_q), .delay(delay),
        .hub_refill_ready(hub_refill_ready));
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (n = 0; n < 20; n++)
        begin
            @(posedge core_clk);
            if (!avs_waitrequest)
                break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20)
        begin
            mismatches++;
            report_and_stop();
        end
        // one idle edge so a following call never reassigns the strobes in this step
        @(posedge core_clk);
    endtask
    // offset is in instructions; shared mode scales it and the step by four
    function automatic logic [19:0] rel(input instr_req_t r);
        logic [19:0] off;
        off = r.aug_valid ? {r.aug_bits[10:0], r.word[8:0]} : {{11{r.word[8]}}, r.word[8:0]};
        return r.pc + (r.hub_exec ? 20'h00004 : 20'h00001) + (r.hub_exec ? off << 2 : off);
    endfunction
    function automatic logic [31:0] mk(input logic [3:0] c, input logic i, input logic [8:0] d, input logic [8:0] s);
        return {c, 7'h5E, 2'b01, i, d, s};
    endfunction
    // present one instruction and time its answer from the accepting edge
    task automatic run(input instr_req_t r, input logic tk, input logic [19:0] tgt, input int lat);
        int e;
        req <= r;
        instr_valid <= 1'b1;
        for (e = 1; e < 40; e++)
        begin
            @(posedge core_clk);
            if (instr_busy_q)
                instr_valid <= 1'b0;
            if (rsp_q.done)
                break;
        end
        if (e == 40)
        begin
            mismatches++;
            report_and_stop();
        end
        check(e - 2, lat);
        check(rsp_q.pc_load, tk);
        if (tk)
            check(rsp_q.pc_target, tgt);
        if (tk)
            last_tgt = tgt;
        taken_n += tk;
    endtask
    ////////////////////////////////////////
    initial
    begin
        instr_req_t r;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        bus(1'b0, REG_CTRL, 32'h0, rd);
        check(rd, CTRL_RESET);
        bus(1'b0, 4'h2, 32'h0, rd);
        check(rd, 32'h0);
        // every flag code except the fifo wrap pair, both senses, tested flag set with others clear and the reverse
        r = '0;
        for (int i = 0; i < 8; i++)
            for (int p = 0; p < 2; p++)
                for (int f = 0; f < 2; f++)
                begin
                    flags <= event_flags_t'(f ? 8'h01 << bits[i] : ~(8'h01 << bits[i]));
                    r.word = mk(4'hF, 1'b1, codes[i] | (p ? 9'h010 : 9'h000), i[0] ? 9'h100 : 9'h0FF);
                    r.pc = 20'(i * 3);
                    run(r, 1'(f ^ p), rel(r), (f ^ p) ? 4 : 2);
                end
        // register target in shared mode, prompt then slow refill
        flags <= event_flags_t'(8'h08);
        r.word = mk(4'hF, 1'b0, 9'h004, 9'h000);
        r.src_value = 20'hABCDE;
        r.hub_exec = 1'b1;
        run(r, 1'b1, 20'hABCDE, 13);
        delay <= 5'h0F;
        run(r, 1'b1, 20'hABCDE, 16);
        delay <= 5'h1F;
        run(r, 1'b1, 20'hABCDE, 20);
        // augmented offsets at both ends of the range
        r.word = mk(4'hF, 1'b1, 9'h004, 9'h000);
        r.aug_valid = 1'b1;
        r.aug_bits = 23'h000400;
        r.pc = 20'h00100;
        run(r, 1'b1, rel(r), 20);
        r.word = mk(4'hF, 1'b1, 9'h004, 9'h1FF);
        r.aug_bits = 23'h0003FF;
        r.hub_exec = 1'b0;
        run(r, 1'b1, rel(r), 4);
        r.aug_valid = 1'b0;
        r.hub_exec = 1'b1;
        run(r, 1'b1, rel(r), 20);
        r.word = mk(4'hF, 1'b1, 9'h014, 9'h1FF);
        run(r, 1'b0, 20'h0, 2);
        // condition field gating and foreign words
        r.hub_exec = 1'b0;
        r.flag_c = 1'b1;
        r.word = mk(4'h1, 1'b1, 9'h004, 9'h010);
        run(r, 1'b0, 20'h0, 2);
        r.flag_c = 1'b0;
        run(r, 1'b1, rel(r), 4);
        r.word = mk(4'h0, 1'b1, 9'h004, 9'h010);
        run(r, 1'b0, 20'h0, 2);
        r.word = {4'hF, 7'h5D, 2'b01, 1'b1, 9'h004, 9'h010};
        run(r, 1'b0, 20'h0, 2);
        r.word = {4'hF, 7'h5E, 2'b00, 1'b1, 9'h004, 9'h010};
        run(r, 1'b0, 20'h0, 2);
        // block of two words, consumed back to back
        bus(1'b1, REG_CTRL, 32'h0002_0001, rd);
        fifo_start <= 1'b1;
        @(posedge core_clk);
        fifo_start <= 1'b0;
        fifo_advance <= 1'b1;
        @(posedge core_clk);
        @(posedge core_clk);
        check(fifo_wrap_q, 1'b0);
        fifo_advance <= 1'b0;
        @(posedge core_clk);
        check(fifo_wrap_q, 1'b1);
        bus(1'b0, REG_STATUS, 32'h0, rd);
        check(rd, 32'h0000_0002);
        r.word = mk(4'hF, 1'b1, 9'h009, 9'h020);
        run(r, 1'b1, rel(r), 4);
        run(r, 1'b0, 20'h0, 2);
        r.word = mk(4'hF, 1'b1, 9'h019, 9'h020);
        run(r, 1'b1, rel(r), 4);
        // read-only counters ignore writes
        bus(1'b1, REG_TAKEN_COUNT, 32'h0, rd);
        bus(1'b0, REG_TAKEN_COUNT, 32'h0, rd);
        check(rd, taken_n);
        bus(1'b0, REG_LAST_TARGET, 32'h0, rd);
        check(rd[19:0], last_tgt);
        report_and_stop();
    end
endmodule
